// File: rtl/cbp_regs.svh
`ifndef CBP_REGS_SVH
`define CBP_REGS_SVH

// ----------------------------------------------------------------
// Stream field widths and patterns
// ----------------------------------------------------------------
`define CBP_SYNC_PAT 5'h12
`define CBP_LEN_W 24
`define CBP_STOP_BITS 8
`define CBP_ID_HDR_BITS 14
`define CBP_ID_MODE_LO 14
`define CBP_ID_CODE_LO 58
`define CBP_ID_BITS 78
`define CBP_ID_CODE_W 20
`define CBP_ADDR_W 14
`define CBP_POST_ADDR 14'h3FFF
`define CBP_POST_CHK 8'hFF
`define CBP_MODE_AUTO 2'h0
`define CBP_MODE_EXPL 2'h1
`define CBP_CNT_W 16

`endif

// File: rtl/cbp_pkg.sv
package cbp_pkg;

    typedef enum logic [3:0] {
        ST_HUNT,
        ST_LEN,
        ST_STOP,
        ST_GAP,
        ST_START2,
        ST_ID,
        ST_DATA,
        ST_ALIGN,
        ST_ADDR,
        ST_CHK,
        ST_DONE,
        ST_ERR
    } cbp_state_t;

    typedef enum logic [1:0] {
        FK_NONE,
        FK_ID,
        FK_DATA,
        FK_ADDR
    } cbp_kind_t;

endpackage

// File: rtl/cbp_mem_if.sv
interface cbp_mem_if #(
    parameter int AW = 3
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;

    modport ctrl (
        output wr_en,
        output wr_addr,
        output wr_data,
        output rd_en,
        output rd_addr,
        input rd_data
    );

    modport mem (
        input wr_en,
        input wr_addr,
        input wr_data,
        input rd_en,
        input rd_addr,
        output rd_data
    );
endinterface

// File: rtl/cbp_frame_mem.sv
module cbp_frame_mem #(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic ref_clk,
    cbp_mem_if.mem bus
);
    generate
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad
            $error("DEPTH must lie between 1 and 2**AW");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Frame byte store
    // ----------------------------------------------------------------
    // Data bytes carry no reset; only the read register is used.
    logic [7:0] store [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (bus.wr_en) begin
            store[bus.wr_addr] <= bus.wr_data;
        end
        if (bus.rd_en) begin
            bus.rd_data <= store[bus.rd_addr];
        end
    end
endmodule

// File: rtl/cbp_loader.sv
`include "cbp_regs.svh"

module cbp_loader #(
    parameter int DATA_BITS = 64,
    // Arbitrary identification value; set it per target device.
    parameter logic [19:0] DEVICE_ID = 20'h3C5A1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic program_restart_n,
    input wire logic config_clock,
    input wire logic config_data,
    output logic config_status,
    output logic config_done,
    output logic load_explicit,
    output logic err_id,
    output logic err_align,
    output logic err_chk,
    output logic cfg_wr_valid,
    output logic [`CBP_ADDR_W-1:0] cfg_wr_addr,
    output logic [7:0] cfg_wr_byte,
    output logic [7:0] cfg_wr_data
);
    import cbp_pkg::*;

    localparam int DATA_BYTES = (DATA_BITS + 7) / 8;
    localparam int BW = (DATA_BYTES > 1) ? $clog2(DATA_BYTES) : 1;
    localparam int ALIGN_BITS = (8 - ((2 + DATA_BITS) % 8)) % 8;
    localparam int LAST_SHIFT = (8 - (DATA_BITS % 8)) % 8;
    localparam logic [`CBP_CNT_W-1:0] DATA_LAST =
        `CBP_CNT_W'(DATA_BITS - 1);
    localparam logic [`CBP_CNT_W-1:0] ALIGN_LAST =
        `CBP_CNT_W'(ALIGN_BITS - 1);
    localparam logic [BW-1:0] BYTE_LAST = BW'(DATA_BYTES - 1);

    generate
        if (DATA_BITS < 1 || DATA_BITS > 2040) begin : g_bad
            $error("DATA_BITS must lie between 1 and 2040");
        end
    endgenerate

    cbp_mem_if #(.AW(BW)) mem_bus ();

    cbp_frame_mem #(
        .DEPTH(DATA_BYTES),
        .AW(BW)
    ) u_mem (
        .ref_clk(ref_clk),
        .bus(mem_bus)
    );

    // ----------------------------------------------------------------
    // Parser state
    // ----------------------------------------------------------------
    cbp_state_t state, next_state;
    cbp_kind_t kind, next_kind;
    cbp_kind_t last_kind, next_last_kind;
    logic config_clock_q, next_config_clock_q;
    logic [4:0] hist, next_hist;
    logic [`CBP_CNT_W-1:0] cnt, next_cnt;
    logic [`CBP_LEN_W-1:0] len, next_len;
    logic [`CBP_LEN_W-1:0] clk_cnt, next_clk_cnt;
    logic stop_bad, next_stop_bad;
    logic [7:0] sbyte, next_sbyte;
    logic [2:0] pos, next_pos;
    logic [7:0] chk, next_chk;
    logic [7:0] rx_chk, next_rx_chk;
    logic [1:0] mode, next_mode;
    logic [`CBP_ID_CODE_W-1:0] id_sr, next_id_sr;
    logic [`CBP_ADDR_W-1:0] addr_sr, next_addr_sr;
    logic [`CBP_ADDR_W-1:0] addr_ctr, next_addr_ctr;
    logic [7:0] dacc, next_dacc;
    logic e_id, next_e_id;
    logic e_align, next_e_align;
    logic e_chk, next_e_chk;
    logic done, next_done;
    logic play_go;
    logic [`CBP_ADDR_W-1:0] play_to;

    logic bit_rise;
    logic [7:0] shifted;
    logic [7:0] rx_full;
    logic [7:0] chk_want;
    logic [`CBP_ID_CODE_W-1:0] id_full;
    logic [`CBP_ADDR_W-1:0] addr_full;
    logic frame_bit;
    logic is_post;

    assign bit_rise = config_clock & ~config_clock_q;

    // ----------------------------------------------------------------
    // Parser next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_last_kind = last_kind;
        next_config_clock_q = config_clock;
        next_hist = hist;
        next_cnt = cnt;
        next_len = len;
        next_clk_cnt = clk_cnt;
        next_stop_bad = stop_bad;
        next_sbyte = sbyte;
        next_pos = pos;
        next_chk = chk;
        next_rx_chk = rx_chk;
        next_mode = mode;
        next_id_sr = id_sr;
        next_addr_sr = addr_sr;
        next_addr_ctr = addr_ctr;
        next_dacc = dacc;
        next_e_id = e_id;
        next_e_align = e_align;
        next_e_chk = e_chk;
        next_done = done;
        play_go = 1'b0;
        play_to = addr_ctr;
        mem_bus.wr_en = 1'b0;
        mem_bus.wr_addr = cnt[BW+2:3];
        mem_bus.wr_data = {dacc[6:0], config_data};
        shifted = {dacc[6:0], config_data} << LAST_SHIFT;
        rx_full = {rx_chk[6:0], config_data};
        id_full = {id_sr[`CBP_ID_CODE_W-2:0], config_data};
        addr_full = {addr_sr[`CBP_ADDR_W-2:0], config_data};
        is_post = (addr_sr == `CBP_POST_ADDR);
        chk_want = (kind == FK_ADDR && is_post) ? `CBP_POST_CHK : chk;
        frame_bit = (state == ST_GAP && !config_data) ||
                    state == ST_START2 || state == ST_ID ||
                    state == ST_DATA || state == ST_ALIGN ||
                    state == ST_ADDR;

        if (!program_restart_n) begin
            next_state = ST_HUNT;
            next_hist = 5'h00;
            next_clk_cnt = '0;
            next_last_kind = FK_NONE;
            next_e_id = 1'b0;
            next_e_align = 1'b0;
            next_e_chk = 1'b0;
            next_done = 1'b0;
            next_addr_ctr = '0;
            next_mode = `CBP_MODE_AUTO;
        end else if (bit_rise) begin
            if (clk_cnt != '1) begin
                next_clk_cnt = clk_cnt + 1'b1;
            end
            if (frame_bit) begin
                next_sbyte = {sbyte[6:0], config_data};
                next_pos = pos + 1'b1;
                if (pos == 3'h7) begin
                    next_chk = chk ^ {sbyte[6:0], config_data};
                end
            end
            unique case (state)
                ST_HUNT: begin
                    next_hist = {hist[3:0], config_data};
                    if ({hist[3:0], config_data} == `CBP_SYNC_PAT) begin
                        next_state = ST_LEN;
                        next_cnt = '0;
                    end
                end
                ST_LEN: begin
                    next_len = {len[`CBP_LEN_W-2:0], config_data};
                    next_cnt = cnt + 1'b1;
                    if (cnt == `CBP_CNT_W'(`CBP_LEN_W - 1)) begin
                        next_state = ST_STOP;
                        next_cnt = '0;
                        next_stop_bad = 1'b0;
                    end
                end
                ST_STOP: begin
                    if (!config_data) begin
                        next_stop_bad = 1'b1;
                    end
                    next_cnt = cnt + 1'b1;
                    if (cnt == `CBP_CNT_W'(`CBP_STOP_BITS - 1)) begin
                        next_state = ST_GAP;
                        next_chk = 8'h00;
                        next_pos = 3'h0;
                    end
                end
                ST_GAP: begin
                    if (!config_data) begin
                        if (stop_bad) begin
                            next_e_align = 1'b1;
                            next_state = ST_ERR;
                        end else begin
                            next_state = ST_START2;
                        end
                    end
                end
                ST_START2: begin
                    next_cnt = '0;
                    if (last_kind == FK_NONE) begin
                        next_kind = FK_ID;
                        next_state = ST_ID;
                        if (!config_data) begin
                            next_e_id = 1'b1;
                            next_state = ST_ERR;
                        end
                    end else if (config_data) begin
                        next_kind = FK_DATA;
                        next_state = ST_DATA;
                        if (mode == `CBP_MODE_EXPL && last_kind == FK_DATA) begin
                            next_e_align = 1'b1;
                            next_state = ST_ERR;
                        end
                    end else begin
                        next_kind = FK_ADDR;
                        next_state = ST_ADDR;
                        if (last_kind == FK_ID) begin
                            next_e_align = 1'b1;
                            next_state = ST_ERR;
                        end
                    end
                end
                ST_ID: begin
                    next_cnt = cnt + 1'b1;
                    if (cnt < `CBP_CNT_W'(`CBP_ID_HDR_BITS) &&
                        config_data != (cnt != '0)) begin
                        next_e_id = 1'b1;
                        next_state = ST_ERR;
                    end
                    if (cnt == `CBP_CNT_W'(`CBP_ID_MODE_LO) ||
                        cnt == `CBP_CNT_W'(`CBP_ID_MODE_LO + 1)) begin
                        next_mode = {mode[0], config_data};
                    end
                    if (cnt >= `CBP_CNT_W'(`CBP_ID_CODE_LO)) begin
                        next_id_sr = id_full;
                    end
                    if (cnt == `CBP_CNT_W'(`CBP_ID_BITS - 1)) begin
                        next_state = ST_CHK;
                        next_cnt = '0;
                        if (id_full != DEVICE_ID ||
                            (mode != `CBP_MODE_AUTO &&
                             mode != `CBP_MODE_EXPL)) begin
                            next_e_id = 1'b1;
                            next_state = ST_ERR;
                        end
                    end
                end
                ST_DATA: begin
                    next_dacc = {dacc[6:0], config_data};
                    next_cnt = cnt + 1'b1;
                    if (cnt[2:0] == 3'h7 || cnt == DATA_LAST) begin
                        mem_bus.wr_en = 1'b1;
                    end
                    if (cnt == DATA_LAST) begin
                        mem_bus.wr_data = shifted;
                        next_cnt = '0;
                        next_state = (ALIGN_BITS > 0) ? ST_ALIGN : ST_CHK;
                    end
                end
                ST_ALIGN: begin
                    next_cnt = cnt + 1'b1;
                    if (cnt == ALIGN_LAST) begin
                        next_cnt = '0;
                        next_state = ST_CHK;
                    end
                end
                ST_ADDR: begin
                    next_addr_sr = addr_full;
                    next_cnt = cnt + 1'b1;
                    if (cnt == `CBP_CNT_W'(`CBP_ADDR_W - 1)) begin
                        next_cnt = '0;
                        next_state = ST_CHK;
                    end
                end
                ST_CHK: begin
                    next_rx_chk = rx_full;
                    next_cnt = cnt + 1'b1;
                    if (cnt == `CBP_CNT_W'(7)) begin
                        next_cnt = '0;
                        next_stop_bad = 1'b0;
                        next_state = ST_STOP;
                        next_last_kind = kind;
                        if (rx_full != chk_want) begin
                            next_e_chk = 1'b1;
                            next_state = ST_ERR;
                        end else if (kind == FK_DATA &&
                                     mode == `CBP_MODE_AUTO) begin
                            play_go = 1'b1;
                            next_addr_ctr = addr_ctr + 1'b1;
                        end else if (kind == FK_ADDR && is_post) begin
                            next_state = ST_DONE;
                            if (mode == `CBP_MODE_EXPL &&
                                last_kind != FK_ADDR) begin
                                next_e_align = 1'b1;
                                next_state = ST_ERR;
                            end
                        end else if (kind == FK_ADDR) begin
                            play_to = addr_sr;
                            play_go = 1'b1;
                            if (mode != `CBP_MODE_EXPL) begin
                                next_e_align = 1'b1;
                                next_state = ST_ERR;
                                play_go = 1'b0;
                            end
                        end
                    end
                end
                ST_DONE: begin
                end
                ST_ERR: begin
                end
            endcase
        end
        if (program_restart_n && state == ST_DONE && clk_cnt >= len) begin
            next_done = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_HUNT;
            kind <= FK_NONE;
            last_kind <= FK_NONE;
            config_clock_q <= 1'b0;
            hist <= 5'h00;
            cnt <= '0;
            len <= '0;
            clk_cnt <= '0;
            stop_bad <= 1'b0;
            sbyte <= 8'h00;
            pos <= 3'h0;
            chk <= 8'h00;
            rx_chk <= 8'h00;
            mode <= `CBP_MODE_AUTO;
            id_sr <= '0;
            addr_sr <= '0;
            addr_ctr <= '0;
            dacc <= 8'h00;
            e_id <= 1'b0;
            e_align <= 1'b0;
            e_chk <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            last_kind <= next_last_kind;
            config_clock_q <= next_config_clock_q;
            hist <= next_hist;
            cnt <= next_cnt;
            len <= next_len;
            clk_cnt <= next_clk_cnt;
            stop_bad <= next_stop_bad;
            sbyte <= next_sbyte;
            pos <= next_pos;
            chk <= next_chk;
            rx_chk <= next_rx_chk;
            mode <= next_mode;
            id_sr <= next_id_sr;
            addr_sr <= next_addr_sr;
            addr_ctr <= next_addr_ctr;
            dacc <= next_dacc;
            e_id <= next_e_id;
            e_align <= next_e_align;
            e_chk <= next_e_chk;
            done <= next_done;
        end
    end

    // ----------------------------------------------------------------
    // Frame playback into configuration memory
    // ----------------------------------------------------------------
    // Playback reads one byte per ref_clk, so each byte is read out before
    // the next data frame can overwrite it in the byte store.
    logic play_on, next_play_on;
    logic [BW-1:0] play_idx, next_play_idx;
    logic [`CBP_ADDR_W-1:0] play_addr, next_play_addr;
    logic wv, next_wv;
    logic [`CBP_ADDR_W-1:0] wa, next_wa;
    logic [7:0] wb, next_wb;

    always_comb begin
        next_play_on = play_on;
        next_play_idx = play_idx;
        next_play_addr = play_addr;
        next_wv = play_on;
        next_wa = play_addr;
        next_wb = 8'(play_idx);
        mem_bus.rd_en = play_on;
        mem_bus.rd_addr = play_idx;
        if (play_on) begin
            next_play_idx = play_idx + 1'b1;
            if (play_idx == BYTE_LAST) begin
                next_play_on = 1'b0;
            end
        end
        if (play_go) begin
            next_play_on = 1'b1;
            next_play_idx = '0;
            next_play_addr = play_to;
        end
        if (!program_restart_n) begin
            next_play_on = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            play_on <= 1'b0;
            play_idx <= '0;
            play_addr <= '0;
            wv <= 1'b0;
            wa <= '0;
            wb <= 8'h00;
        end else begin
            play_on <= next_play_on;
            play_idx <= next_play_idx;
            play_addr <= next_play_addr;
            wv <= next_wv;
            wa <= next_wa;
            wb <= next_wb;
        end
    end

    assign cfg_wr_valid = wv;
    assign cfg_wr_addr = wa;
    assign cfg_wr_byte = wb;
    assign cfg_wr_data = wv ? mem_bus.rd_data : 8'h00;
    assign err_id = e_id;
    assign err_align = e_align;
    assign err_chk = e_chk;
    assign config_status = ~(e_id | e_align | e_chk);
    assign config_done = done;
    assign load_explicit = (mode == `CBP_MODE_EXPL);
endmodule

// File: verif/cbp_loader_assertions.sv
`include "cbp_regs.svh"

// ----------------------------------------
// Loader port checks
// ----------------------------------------
module cbp_loader_checker #(
    parameter int DATA_BITS = 64
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic program_restart_n,
    input wire logic config_clock,
    input wire logic config_data,
    input wire logic config_status,
    input wire logic config_done,
    input wire logic load_explicit,
    input wire logic err_id,
    input wire logic err_align,
    input wire logic err_chk,
    input wire logic cfg_wr_valid,
    input wire logic [`CBP_ADDR_W-1:0] cfg_wr_addr,
    input wire logic [7:0] cfg_wr_byte,
    input wire logic [7:0] cfg_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAST = (DATA_BITS + 7) / 8 - 1;
    logic any_err;
    assign any_err = err_id || err_align || err_chk;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_status_follows: assert property (
        config_status == !any_err)
        else $error("status does not follow error flags");
    a_err_sticky: assert property (
        any_err && program_restart_n |=> $stable({err_id, err_align, err_chk}))
        else $error("error flags changed before restart");
    a_restart_clears: assert property (
        !program_restart_n |=> !(any_err || config_done || load_explicit))
        else $error("restart left a flag set");
    a_err_on_bit: assert property (
        $rose(any_err) |-> $past(config_clock) && !$past(config_clock, 2))
        else $error("error rose without a clock rise");
    a_wr_delay: assert property (
        $rose(cfg_wr_valid) |-> $past(config_clock, 2) &&
        !$past(config_clock, 3))
        else $error("write burst not two cycles after checksum");
    a_wr_burst: assert property (
        $rose(cfg_wr_valid) |-> cfg_wr_byte == 8'h00 ##LAST
        cfg_wr_valid ##1 !cfg_wr_valid)
        else $error("write burst length wrong");
    a_wr_step: assert property (
        cfg_wr_valid && $past(cfg_wr_valid) |->
        cfg_wr_byte == $past(cfg_wr_byte) + 8'h01 && $stable(cfg_wr_addr))
        else $error("byte index or address slipped in burst");
    a_wr_quiet: assert property (
        !cfg_wr_valid |-> cfg_wr_data == 8'h00)
        else $error("write data not zero while idle");
    a_err_no_wr: assert property (
        err_id || err_chk |-> !cfg_wr_valid)
        else $error("write after a rejected frame");
    a_done_clean: assert property (
        config_done |-> config_status && !cfg_wr_valid)
        else $error("done with error or pending write");
endmodule

bind cbp_loader cbp_loader_checker #(.DATA_BITS(DATA_BITS)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .program_restart_n(program_restart_n), .config_clock(config_clock),
    .config_data(config_data), .config_status(config_status),
    .config_done(config_done), .load_explicit(load_explicit),
    .err_id(err_id), .err_align(err_align), .err_chk(err_chk),
    .cfg_wr_valid(cfg_wr_valid), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_byte(cfg_wr_byte), .cfg_wr_data(cfg_wr_data)
);

// File: verif/cbp_source.sv
// ----------------------------------------
// Serial bit stream source
// ----------------------------------------
module cbp_source (
    input wire logic ref_clk,
    output logic config_clock,
    output logic config_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic q[$];
    logic [7:0] sum;
    logic [7:0] acc;
    int fb;
    initial begin
        config_clock = 1'b0;
        config_data = 1'b1;
        sum = 8'h00;
        acc = 8'h00;
        fb = 0;
    end
    task automatic frame();
        sum = 8'h00;
        fb = 0;
    endtask
    // Every full frame byte is folded into the running XOR.
    task automatic push(input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            q.push_back(v[i]);
            acc = {acc[6:0], v[i]};
            fb++;
            if (fb % 8 == 0) begin
                sum = sum ^ acc;
            end
        end
    endtask
    // The clock stands low between loads; the idle line shows the
    // inverse of its last bit so a stale value cannot pass as a bit.
    task automatic play();
        while (q.size() > 0) begin
            @(negedge ref_clk);
            config_clock = 1'b0;
            config_data = q.pop_front();
            @(negedge ref_clk);
            config_clock = 1'b1;
        end
        @(negedge ref_clk);
        config_clock = 1'b0;
        config_data = ~config_data;
    endtask
endmodule

// File: verif/config_bitstream_frame_parser_bench.sv
`include "cbp_regs.svh"

// ----------------------------------------
// Loader bench
// ----------------------------------------
module config_bitstream_frame_parser_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] mode;
        logic [19:0] idv;
        logic [7:0] cx;
        logic [7:0] stop;
        logic [23:0] len;
        logic [4:0] exp;
        logic [2:0] nw;
    } cbp_row_t;
    // Arbitrary identification value.
    localparam logic [19:0] ID = 20'h2B6D4;
    localparam logic [15:0] D0 = 16'hA5C3;
    localparam logic [15:0] D1 = 16'h1E7F;
    localparam logic [13:0] A1 = 14'h0005;
    localparam logic [13:0] A2 = 14'h3FFE;
    localparam logic [23:0] L = 24'h000010;
    // Flags are {done, explicit, id, align, checksum}.
    cbp_row_t rows[9] = '{
        '{2'h0, ID, 8'h00, 8'hFF, L, 5'h10, 3'h4},
        '{2'h1, ID, 8'h00, 8'hFF, L, 5'h18, 3'h4},
        '{2'h0, ID, 8'h00, 8'hFF, 24'hFFFFFF, 5'h00, 3'h4},
        '{2'h0, ID, 8'h01, 8'hFF, L, 5'h01, 3'h0},
        '{2'h0, ID ^ 20'h00001, 8'h00, 8'hFF, L, 5'h04, 3'h0},
        '{2'h0, ID, 8'h00, 8'hEF, L, 5'h02, 3'h2},
        '{2'h2, ID, 8'h00, 8'hFF, L, 5'h04, 3'h0},
        '{2'h3, ID, 8'h00, 8'hFF, L, 5'h04, 3'h0},
        '{2'h1, ID, 8'h00, 8'hFF, L, 5'h0A, 3'h0}
    };
    logic ref_clk;
    logic rst_n;
    logic program_restart_n;
    logic config_clock;
    logic config_data;
    logic config_status;
    logic config_done;
    logic load_explicit;
    logic err_id;
    logic err_align;
    logic err_chk;
    logic cfg_wr_valid;
    logic [`CBP_ADDR_W-1:0] cfg_wr_addr;
    logic [7:0] cfg_wr_byte;
    logic [7:0] cfg_wr_data;
    logic [29:0] wq[$];
    int errors = 0;
    int compares = 0;

    cbp_source src (
        .ref_clk(ref_clk),
        .config_clock(config_clock),
        .config_data(config_data)
    );
    cbp_loader #(.DATA_BITS(16), .DEVICE_ID(ID)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .program_restart_n(program_restart_n),
        .config_clock(config_clock), .config_data(config_data),
        .config_status(config_status), .config_done(config_done),
        .load_explicit(load_explicit), .err_id(err_id),
        .err_align(err_align), .err_chk(err_chk),
        .cfg_wr_valid(cfg_wr_valid), .cfg_wr_addr(cfg_wr_addr),
        .cfg_wr_byte(cfg_wr_byte), .cfg_wr_data(cfg_wr_data)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        if (cfg_wr_valid === 1'b1) begin
            wq.push_back({cfg_wr_addr, cfg_wr_byte, cfg_wr_data});
        end
    end

    task automatic stop_test();
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [29:0] got, input logic [29:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic data(input logic [15:0] w, input logic [7:0] cx);
        src.frame();
        src.push(64'({2'b01, w, 6'h00}), 24);
        src.push(64'(src.sum ^ cx), 8);
    endtask
    task automatic addr(input logic [13:0] a);
        src.frame();
        src.push(64'({2'b00, a}), 16);
        src.push(64'({src.sum, 8'hFF}), 16);
    endtask
    task automatic load(input cbp_row_t r);
        src.push(64'hF2, 8);
        src.push(64'(r.len), 24);
        src.push(64'hFF, 8);
        src.frame();
        src.push(64'({2'b01, 14'h1FFF, r.mode}), 18);
        src.push(64'h0, 42);
        src.push(64'(r.idv), 20);
        src.push(64'({src.sum, 8'hFF}), 16);
        data(D0, r.cx);
        src.push(64'(r.stop), 8);
        if (r.mode == `CBP_MODE_EXPL) begin
            // With no writes wanted, the postamble follows the data frame.
            if (r.nw != 3'h0) begin
                addr(A1);
                addr(A2);
            end
        end else begin
            data(D1, 8'h00);
            src.push(64'hFF, 8);
        end
        src.push(64'h3FFF, 16);
        src.push(64'hFFFF, 16);
        src.play();
    endtask

    initial begin
        cbp_row_t r;
        logic [15:0] w;
        logic [13:0] a;
        rst_n = 1'b0;
        program_restart_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(30'({err_id, err_align, err_chk, config_done, config_status}),
            30'h1);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        foreach (rows[k]) begin
            r = rows[k];
            wq.delete();
            load(r);
            repeat (8) @(negedge ref_clk);
            chk(30'({config_done, load_explicit, err_id, err_align, err_chk}),
                30'(r.exp));
            chk(30'(config_status), 30'(~|r.exp[2:0]));
            chk(30'(wq.size()), 30'(r.nw));
            for (int i = 0; i < r.nw; i++) begin
                w = (i[1] && r.mode != `CBP_MODE_EXPL) ? D1 : D0;
                a = (r.mode == `CBP_MODE_EXPL) ? (i[1] ? A2 : A1)
                    : {13'h0, i[1]};
                chk(wq[i], {a, 7'h00, i[0], i[0] ? w[7:0] : w[15:8]});
            end
            if (k % 2) begin
                rst_n = 1'b0;
            end else begin
                program_restart_n = 1'b0;
            end
            repeat (2) @(negedge ref_clk);
            chk(30'({config_done, load_explicit, err_id, err_align, err_chk,
                config_status}), 30'h1);
            rst_n = 1'b1;
            program_restart_n = 1'b1;
            repeat (4) @(negedge ref_clk);
        end
        stop_test();
    end
    initial begin
        #300us;
        errors++;
        stop_test();
    end
endmodule
